/* File: hdl/afb_decode.sv */
// opcode field decoder for the two instructions
module afb_decode (
  input wire logic [11:0] insn, // instruction word
  output logic is_and, // and-with-file decoded
  output logic is_bclr, // bit-clear decoded
  output logic dest_file, // result to file register
  output logic [4:0] file_addr, // file register address
  output logic [2:0] bit_sel // bit position
);
  always_comb
  begin
    is_and = (insn[afb_pkg::OP6_HI:afb_pkg::OP6_LO] == afb_pkg::AND_ACCUMULATOR_WITH_FILE_OP);
    is_bclr = (insn[afb_pkg::OP6_HI:afb_pkg::OP4_LO] == afb_pkg::BCF_OP);
    dest_file = insn[afb_pkg::DEST_BIT];
    file_addr = insn[afb_pkg::ADDR_W-1:0];
    bit_sel = insn[afb_pkg::BIT_HI:afb_pkg::BIT_LO];
  end
endmodule // afb_decode

/* File: hdl/afb_exec.sv */
// execute stage for and-with-file and bit-clear instructions
module afb_exec (
  input wire logic mclk, // core clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic insn_valid, // instruction present this cycle
  input wire logic [11:0] insn, // instruction word
  input wire logic [7:0] file_rdata, // file register read data
  input wire logic [7:0] port_pins, // pin levels when address is a port
  input wire logic file_is_port, // addressed file is a port register
  input wire logic prescaler_to_timer, // prescaler assigned to timer
  output logic [4:0] file_raddr, // file register read address
  output logic file_we, // file register write strobe
  output logic [4:0] file_waddr, // file register write address
  output logic [7:0] file_wdata, // file register write data
  output logic [7:0] acc, // working accumulator
  output logic zero_we, // zero flag update strobe
  output logic zero_val, // new zero flag value
  output logic prescaler_clr, // clear prescaler strobe
  output logic insn_done // instruction retired
);
  logic is_and;
  logic is_bclr;
  logic dest_file;
  logic [4:0] addr;
  logic [2:0] bit_sel;
  logic [7:0] operand;
  logic [7:0] result;
  logic to_file;
  logic [7:0] acc_q, acc_d;
  logic we_q, we_d;
  logic [4:0] waddr_q, waddr_d;
  logic [7:0] wdata_q, wdata_d;
  logic zwe_q, zwe_d;
  logic zval_q, zval_d;
  logic pclr_q, pclr_d;
  logic done_q, done_d;

  afb_decode u_dec (
    .insn(insn),
    .is_and(is_and),
    .is_bclr(is_bclr),
    .dest_file(dest_file),
    .file_addr(addr),
    .bit_sel(bit_sel)
  );

  assign file_raddr = addr;

  always_comb
  begin
    operand = file_is_port ? port_pins : file_rdata;
    result = is_and ? (acc_q & operand) : (operand & ~(8'h01 << bit_sel));
    to_file = is_bclr | (is_and & dest_file);
    acc_d = acc_q;
    we_d = 1'b0;
    waddr_d = addr;
    wdata_d = wdata_q;
    zwe_d = 1'b0;
    zval_d = zval_q;
    pclr_d = 1'b0;
    done_d = 1'b0;
    if (insn_valid && (is_and || is_bclr))
    begin
      done_d = 1'b1;
      if (to_file)
      begin
        we_d = 1'b1;
        wdata_d = result;
        pclr_d = (addr == afb_pkg::TIMER_ADDR) & prescaler_to_timer;
      end
      else
      begin
        acc_d = result;
      end
      if (is_and)
      begin
        zwe_d = 1'b1;
        zval_d = (result == 8'h00);
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      acc_q <= afb_pkg::ACC_RESET;
      we_q <= 1'b0;
      waddr_q <= 5'h00;
      wdata_q <= 8'h00;
      zwe_q <= 1'b0;
      zval_q <= 1'b0;
      pclr_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      acc_q <= acc_d;
      we_q <= we_d;
      waddr_q <= waddr_d;
      wdata_q <= wdata_d;
      zwe_q <= zwe_d;
      zval_q <= zval_d;
      pclr_q <= pclr_d;
      done_q <= done_d;
    end
  end

  assign acc = acc_q;
  assign file_we = we_q;
  assign file_waddr = waddr_q;
  assign file_wdata = wdata_q;
  assign zero_we = zwe_q;
  assign zero_val = zval_q;
  assign prescaler_clr = pclr_q;
  assign insn_done = done_q;
endmodule // afb_exec

/* File: hdl/afb_pkg.sv */
// constants for the and-with-file and bit-clear execute block
package afb_pkg;
  localparam int unsigned INSN_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 5;
  localparam logic [5:0] AND_ACCUMULATOR_WITH_FILE_OP = 6'h05;
  localparam logic [3:0] BCF_OP = 4'h4;
  localparam int unsigned OP6_HI = 11;
  localparam int unsigned OP6_LO = 6;
  localparam int unsigned OP4_LO = 8;
  localparam int unsigned DEST_BIT = 5;
  localparam int unsigned BIT_HI = 7;
  localparam int unsigned BIT_LO = 5;
  localparam logic [4:0] TIMER_ADDR = 5'h01;
  localparam logic [7:0] ACC_RESET = 8'h00;
  typedef enum logic [1:0] {
    AFB_IDLE = 2'b00,
    AFB_EXEC = 2'b01
  } afb_state_type;
endpackage : afb_pkg

/* File: tb/afb_exec_props.sv */
// assertion checker for afb_exec
module afb_exec_props (
  input wire logic mclk, sys_rst, insn_valid, file_is_port, prescaler_to_timer, // in
  input wire logic [11:0] insn, // in
  input wire logic [7:0] file_rdata, port_pins, acc, file_wdata, // data
  input wire logic [4:0] file_raddr, file_waddr, // addr
  input wire logic file_we, zero_we, zero_val, prescaler_clr, insn_done // out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // ports read back from pins, not latches
  wire logic [7:0] d = file_is_port ? port_pins : file_rdata, r = acc & d;
  wire logic [7:0] m = d & ~(8'h01 << insn[7:5]);
  wire logic a = insn_valid && insn[11:6] == 6'h05, b = insn_valid && insn[11:8] == 4'h4;
  wire logic w = a && insn[5] || b, t = w && insn[4:0] == 5'h01 && prescaler_to_timer;
  a_and_file: assert property (a && insn[5] |=> file_wdata == $past(r)) else $error("and");
  a_and_acc: assert property (a && !insn[5] |=> acc == $past(r)) else $error("acc");
  a_zero_flag: assert property (a |=> zero_we && zero_val == ($past(r) == 8'h00))
    else $error("zero");
  a_bclr_data: assert property (b |=> !zero_we && file_wdata == $past(m)) else $error("bit");
  a_write_strobe: assert property (file_we == $past(w)) else $error("we");
  a_write_addr: assert property (w |=> file_waddr == $past(file_raddr)) else $error("wa");
  a_done_pulse: assert property (insn_done == ($past(a) || $past(b))) else $error("done");
  a_prescaler_clr: assert property (prescaler_clr == $past(t)) else $error("pre");
  cover property (a && insn[5]);
  cover property (b && file_is_port);
  cover property (t);
endmodule // afb_exec_props
bind afb_exec afb_exec_props i_props (.*);

/* File: tb/afb_exec_tb_top.sv */
// bench for afb_exec
module afb_exec_tb_top;
  timeunit 1ns / 1ps;
  logic mclk = 1'h0, sys_rst = 1'h1, insn_valid = 1'h0, file_is_port = 1'h0;
  logic prescaler_to_timer = 1'h0, file_we, zero_we, zero_val, prescaler_clr, insn_done;
  logic [11:0] insn = 12'h000;
  logic [7:0] file_rdata = 8'h00, port_pins = 8'h00, acc, file_wdata;
  logic [4:0] file_raddr, file_waddr;
  int n_errors = 0, checks = 0, cyc = 0;
  afb_exec i_dut (.*);
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 500) stop_test(1);
  // v = rdata, port select, prescaler; pins always differ from rdata
  task automatic run(logic [11:0] i, logic [9:0] v, logic [12:0] e);
    logic [12:0] g;
    @(posedge mclk);
    insn <= i;
    {file_rdata, file_is_port, prescaler_to_timer, port_pins} <= {v, ~v[9:2]};
    @(posedge mclk);
    #1;
    g = {file_we ? file_wdata : acc, file_we, zero_we, zero_val, prescaler_clr, insn_done};
    checks++;
    n_errors += int'(g !== e);
    if (g !== e) $display("mismatch %h exp %h got %h", i, e, g);
  endtask
  // accumulator resets to zero, so every and result is zero
  task automatic s_and;
    run(12'h161, {8'hC2, 2'h1}, {8'h00, 5'h1F});
    run(12'h145, {8'hFF, 2'h3}, {8'h00, 5'h0D});
    run(12'h5E7, {8'hFF, 2'h1}, {8'h00, 5'h04});
  endtask
  task automatic s_bclr;
    for (int k = 0; k < 8; k++)
      run({4'h4, 3'(k), 5'h01}, {8'hFF, 2'h1}, {~(8'h01 << k), 5'h17});
    run(12'h4E7, {8'h38, 2'h2}, {8'h47, 5'h15});
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    sys_rst <= 1'h0;
    insn_valid <= 1'h1;
    s_and();
    s_bclr();
    stop_test(0);
  end
  task automatic stop_test(int to);
    n_errors += to;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
endmodule // afb_exec_tb_top
